// File: hw/fast_stream_pkg.sv
// package: constants and types for the fast waveform streamer
package fast_stream_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned COUNT_W = 16;
  localparam int unsigned REC_AW = 10;
  localparam logic [REC_AW-1:0] REC_LAST = 10'h3ff;
  localparam logic [COUNT_W-1:0] COUNT_MIN = 16'h0001;
  // register byte addresses
  localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] A_COUNT = 5'h04;
  localparam logic [ADDR_W-1:0] A_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] A_DONE = 5'h0c;
  localparam logic [ADDR_W-1:0] A_QUERY = 5'h10;
  // control fields
  localparam int unsigned B_ARM = 0;
  localparam int unsigned B_DELAYED = 1;
  localparam int unsigned B_LINK_LO = 2;
  localparam int unsigned B_FROZEN = 4;
  localparam logic [1:0] LINK_ONE = 2'h0;
  localparam logic [1:0] LINK_TWO = 2'h1;
  localparam logic [1:0] LINK_BOTH = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // slot index = {delayed, channel two}
  localparam logic [1:0] SLOTS = 2'h3;
  typedef enum logic [2:0] {S_IDLE, S_ACQ, S_WAIT, S_SEND, S_NEXT} state_t;
endpackage : fast_stream_pkg

// File: hw/fast_stream.sv
// streams saved waveform records to a listening bus controller
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module fast_stream (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [4:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [4:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic talk_addr, // addressed as talker, async pin level
  input wire logic cmd_in, // other bus command pending, async level
  output logic cmd_accept, // command decoding enabled
  input wire logic save_wr, // save-move writes a sample
  input wire logic [1:0] save_slot, // slot being written
  input wire logic [9:0] save_addr, // sample index
  input wire logic [7:0] save_data, // sample byte
  input wire logic save_done, // save-move completion pulse
  output logic acq_req, // request one acquisition, pulse
  output logic [7:0] bus_data, // byte to the handshake controller
  output logic bus_valid, // byte offered
  input wire logic bus_ready, // handshake accepts byte
  output logic streaming, // fast streaming in progress
  output logic [1:0] stream_slot // slot of record being sent
);
  logic [7:0] slot_mem [4*1024]; // four save slots
  logic [7:0] hold_mem [1024]; // holding buffer for the ordinary query
  logic [2:0] talk_s_q;
  logic [2:0] talk_s_d;
  logic talk_f_q;
  logic talk_f_d;
  logic [2:0] cmd_s_q;
  logic [2:0] cmd_s_d;
  logic arm_q;
  logic arm_d;
  logic delayed_q;
  logic delayed_d;
  logic frozen_q;
  logic frozen_d;
  logic [1:0] link_q;
  logic [1:0] link_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] left_q;
  logic [15:0] left_d;
  logic [15:0] done_q;
  logic [15:0] done_d;
  fast_stream_pkg::state_t st_q;
  fast_stream_pkg::state_t st_d;
  logic chan_q;
  logic chan_d;
  logic [9:0] idx_q;
  logic [9:0] idx_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic bvalid_q;
  logic bvalid_d;
  logic rvalid_q;
  logic rvalid_d;
  logic aw_q;
  logic aw_d;
  logic w_q;
  logic w_d;
  logic [4:0] awaddr_q;
  logic [4:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic talk_rise;
  logic cmd_level;
  logic do_write;
  logic [1:0] cur_slot;
  logic [7:0] mem_rd;
  logic [7:0] hold_rd;

  function automatic logic [11:0] mem_index(input logic [1:0] slot, input logic [9:0] a);
    mem_index = {slot, a};
  endfunction : mem_index

  // slot follows source group and current channel
  assign cur_slot = {delayed_q, chan_q};
  assign stream_slot = cur_slot;
  assign streaming = (st_q != fast_stream_pkg::S_IDLE);
  // three stage pin sampling; a change counts when stages two and three agree
  assign talk_rise = talk_s_q[1] & talk_s_q[2] & ~talk_f_q;
  assign cmd_level = cmd_s_q[1] & cmd_s_q[2];
  assign cmd_accept = ~streaming & cmd_level;
  assign acq_req = (st_q == fast_stream_pkg::S_ACQ);
  assign bus_valid = (st_q == fast_stream_pkg::S_SEND);
  // read register follows the next index, so it always holds the offered byte
  assign bus_data = mem_rd;
  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready = ~w_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign do_write = aw_q & w_q & ~bvalid_q;

  // save memory write and raw read, no processing on the fast path
  always_ff @(posedge clk) begin
    if (save_wr) begin
      slot_mem[mem_index(save_slot, save_addr)] <= save_data;
    end
    mem_rd <= slot_mem[mem_index(cur_slot, idx_d)];
  end

  // ordinary query copies the selected slot into the holding buffer
  always_ff @(posedge clk) begin
    if (save_done && !streaming) begin
      hold_mem[idx_q] <= slot_mem[mem_index(cur_slot, idx_q)];
    end
    hold_rd <= hold_mem[idx_q];
  end

  always_comb begin
    talk_s_d = {talk_s_q[1:0], talk_addr};
    cmd_s_d = {cmd_s_q[1:0], cmd_in};
    talk_f_d = talk_f_q;
    if (talk_s_q[1] == talk_s_q[2]) begin
      talk_f_d = talk_s_q[2];
    end
  end

  always_comb begin
    arm_d = arm_q;
    delayed_d = delayed_q;
    frozen_d = frozen_q;
    link_d = link_q;
    count_d = count_q;
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = fast_stream_pkg::RESP_OKAY;
      if (awaddr_q == fast_stream_pkg::A_CTRL) begin
        if (!streaming) begin
          arm_d = wdata_q[fast_stream_pkg::B_ARM];
          delayed_d = wdata_q[fast_stream_pkg::B_DELAYED];
          link_d = wdata_q[fast_stream_pkg::B_LINK_LO +: 2];
        end
        frozen_d = wdata_q[fast_stream_pkg::B_FROZEN];
      end else if (awaddr_q == fast_stream_pkg::A_COUNT) begin
        if (wdata_q[15:0] >= fast_stream_pkg::COUNT_MIN && !streaming) begin
          count_d = wdata_q[15:0];
        end else begin
          bresp_d = fast_stream_pkg::RESP_SLVERR;
        end
      end else begin
        bresp_d = fast_stream_pkg::RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = fast_stream_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr == fast_stream_pkg::A_CTRL) begin
        rdata_d[fast_stream_pkg::B_ARM] = arm_q;
        rdata_d[fast_stream_pkg::B_DELAYED] = delayed_q;
        rdata_d[fast_stream_pkg::B_LINK_LO +: 2] = link_q;
        rdata_d[fast_stream_pkg::B_FROZEN] = frozen_q;
      end else if (s_axi_araddr == fast_stream_pkg::A_COUNT) begin
        rdata_d[15:0] = count_q;
      end else if (s_axi_araddr == fast_stream_pkg::A_STATUS) begin
        rdata_d = {13'h0000, st_q, left_q};
      end else if (s_axi_araddr == fast_stream_pkg::A_DONE) begin
        rdata_d[15:0] = done_q;
      end else if (s_axi_araddr == fast_stream_pkg::A_QUERY) begin
        rdata_d[7:0] = hold_rd;
      end else begin
        rresp_d = fast_stream_pkg::RESP_SLVERR;
      end
    end
    // completion clears the pending request; set by software loses here
    if (st_q == fast_stream_pkg::S_NEXT && left_q == fast_stream_pkg::COUNT_MIN
        && (link_q != fast_stream_pkg::LINK_BOTH || chan_q)) begin
      arm_d = 1'b0;
    end
  end

  always_comb begin
    st_d = st_q;
    chan_d = chan_q;
    idx_d = idx_q;
    left_d = left_q;
    done_d = done_q;
    case (st_q)
      fast_stream_pkg::S_IDLE: begin
        if (save_done && idx_q != fast_stream_pkg::REC_LAST) begin
          idx_d = idx_q + 10'h001;
        end else if (!save_done) begin
          idx_d = '0;
        end
        chan_d = (link_q == fast_stream_pkg::LINK_TWO);
        if (talk_rise && arm_q) begin
          left_d = count_q;
          done_d = '0;
          idx_d = '0;
          chan_d = (link_q == fast_stream_pkg::LINK_TWO);
          st_d = frozen_q ? fast_stream_pkg::S_WAIT : fast_stream_pkg::S_ACQ;
        end
      end
      fast_stream_pkg::S_ACQ: begin
        st_d = fast_stream_pkg::S_WAIT;
      end
      fast_stream_pkg::S_WAIT: begin
        if (save_done || frozen_q) begin
          idx_d = '0;
          st_d = fast_stream_pkg::S_SEND;
        end
      end
      fast_stream_pkg::S_SEND: begin
        if (bus_ready) begin
          if (idx_q == fast_stream_pkg::REC_LAST) begin
            st_d = fast_stream_pkg::S_NEXT;
          end else begin
            idx_d = idx_q + 10'h001;
          end
        end
      end
      fast_stream_pkg::S_NEXT: begin
        idx_d = '0;
        if (link_q == fast_stream_pkg::LINK_BOTH && !chan_q) begin
          chan_d = 1'b1;
          // channel two record also gets a fresh acquisition unless frozen
          st_d = frozen_q ? fast_stream_pkg::S_WAIT : fast_stream_pkg::S_ACQ;
        end else begin
          chan_d = (link_q == fast_stream_pkg::LINK_TWO);
          done_d = done_q + 16'h0001;
          left_d = left_q - 16'h0001;
          if (left_q == fast_stream_pkg::COUNT_MIN) begin
            st_d = fast_stream_pkg::S_IDLE;
          end else begin
            st_d = frozen_q ? fast_stream_pkg::S_WAIT : fast_stream_pkg::S_ACQ;
          end
        end
      end
      default: st_d = fast_stream_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      talk_s_q <= '0;
      cmd_s_q <= '0;
      talk_f_q <= 1'b0;
      arm_q <= 1'b0;
      delayed_q <= 1'b0;
      frozen_q <= 1'b0;
      link_q <= fast_stream_pkg::LINK_ONE;
      count_q <= fast_stream_pkg::COUNT_MIN;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= fast_stream_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= fast_stream_pkg::RESP_OKAY;
      st_q <= fast_stream_pkg::S_IDLE;
      chan_q <= 1'b0;
      idx_q <= '0;
      left_q <= '0;
      done_q <= '0;
    end else begin
      talk_s_q <= talk_s_d;
      cmd_s_q <= cmd_s_d;
      talk_f_q <= talk_f_d;
      arm_q <= arm_d;
      delayed_q <= delayed_d;
      frozen_q <= frozen_d;
      link_q <= link_d;
      count_q <= count_d;
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      st_q <= st_d;
      chan_q <= chan_d;
      idx_q <= idx_d;
      left_q <= left_d;
      done_q <= done_d;
    end
  end
endmodule : fast_stream

// File: bench/fast_stream_chk.sv
// checker: port assertions for the waveform streamer
`timescale 1ns/1ps
module fast_stream_chk (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic talk_addr, // talk pin
  input wire logic acq_req, // acquire pulse
  input wire logic cmd_accept, // decoding on
  input wire logic [7:0] bus_data, // byte
  input wire logic bus_valid, // byte offered
  input wire logic bus_ready, // byte taken
  input wire logic streaming, // busy
  input wire logic [1:0] stream_slot, // slot
  input wire logic [1:0] s_axi_bresp, // wr resp
  input wire logic s_axi_bvalid, // wr valid
  input wire logic s_axi_bready, // wr ready
  input wire logic [31:0] s_axi_rdata, // rd data
  input wire logic s_axi_rvalid, // rd valid
  input wire logic s_axi_rready // rd ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence acq_gap_s;
    !acq_req && !bus_valid;
  endsequence
  sequence stall_s;
    bus_valid && $past(bus_valid) && !bus_ready;
  endsequence
  acq_pulse_a: assert property (acq_req |=> acq_gap_s)
    else $error("acquire pulse not followed by wait");
  acq_inside_a: assert property (acq_req |-> streaming)
    else $error("acquire outside stream");
  talk_start_a: assert property ($rose(streaming) |-> talk_addr && $past(talk_addr))
    else $error("stream began without talk");
  quiet_stream_a: assert property (streaming |-> !cmd_accept)
    else $error("commands decoded while streaming");
  offer_stream_a: assert property (bus_valid |-> streaming)
    else $error("byte offered while idle");
  byte_hold_a: assert property (stall_s |=> bus_valid && $stable(bus_data) && $stable(stream_slot))
    else $error("byte changed while stalled");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : fast_stream_chk
bind fast_stream fast_stream_chk u_chk (.*);

// File: bench/listener_model.sv
// listener model: takes bytes, stalls at random
`timescale 1ns/1ps
module listener_model (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic bus_valid, // byte offered
  input wire logic [7:0] bus_data, // byte
  input wire logic [1:0] stream_slot, // slot
  input wire logic slow, // random stalls
  output logic bus_ready // byte taken
);
  logic [7:0] got [$];
  logic [1:0] gslot [$];
  int lseed = 32'h7215;
  // ready only after valid was seen, never in the first offered cycle
  always_ff @(posedge clk) begin
    if (bus_valid && bus_ready) begin
      got.push_back(bus_data);
      gslot.push_back(stream_slot);
    end
    bus_ready <= !rst && bus_valid && (!slow || (($random(lseed) & 1) != 0));
  end
endmodule : listener_model

// File: bench/fast_stream_tb.sv
// testbench: streamer with listener and acquisition stand-in
`timescale 1ns/1ps
module fast_stream_tb;
  logic clk = 1'b0, rst = 1'b1, talk_addr = 1'b0, cmd_in = 1'b0, slow = 1'b0;
  logic save_wr = 1'b0, save_done = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cmd_accept, acq_req, bus_valid, bus_ready, streaming;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] save_slot = 2'h0, s_axi_bresp, s_axi_rresp, stream_slot;
  logic [9:0] save_addr = 10'h0;
  logic [7:0] save_data = 8'h0, bus_data;
  logic [7:0] salt [4];
  logic [7:0] exp_salt [$];
  int seed = 32'h7215;
  int mismatches = 0;
  int num_checks = 0;
  fast_stream dut (.*);
  listener_model lis (.*);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic timeout;
    mismatches++;
    $display("[ERR] wait expected done seen timeout");
    finish_test();
  endtask : timeout
  task automatic axi(input bit wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] r);
    int n;
    bit aw, w, ar, b;
    n = 0;
    b = 0;
    @(posedge clk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!b && n < 50) begin
      @(posedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      b = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!b) timeout();
  endtask : axi
  task automatic fill(input logic [1:0] s, input logic [7:0] k);
    for (int i = 0; i < 1024; i++) begin
      @(posedge clk);
      save_wr <= 1'b1;
      save_slot <= s;
      save_addr <= i[9:0];
      save_data <= i[7:0] ^ k;
    end
    @(posedge clk);
    save_wr <= 1'b0;
    save_done <= 1'b1;
    @(posedge clk);
    save_done <= 1'b0;
  endtask : fill
  function automatic logic [1:0] exp_slot(input logic dly, input logic [1:0] link, input int r);
    return {dly, link == fast_stream_pkg::LINK_BOTH ? r[0] : link == fast_stream_pkg::LINK_TWO};
  endfunction : exp_slot
  // acquisition stand-in: each request refreshes the slot being sent
  initial begin : acq_side
    logic [1:0] s;
    forever begin
      @(negedge clk);
      if (acq_req === 1'b1) begin
        s = stream_slot;
        salt[s] = 8'($random(seed));
        exp_salt.push_back(salt[s]);
        fill(s, salt[s]);
      end
    end
  end
  task automatic run(input logic dly, input logic [1:0] link, input logic frz, input logic [15:0] cnt);
    logic [31:0] rd;
    logic [1:0] r;
    int n, nrec;
    nrec = link == fast_stream_pkg::LINK_BOTH ? 2 * cnt : cnt;
    lis.got.delete();
    lis.gslot.delete();
    exp_salt.delete();
    slow <= ~slow;
    for (int k = 0; k < nrec; k++) begin
      if (frz) exp_salt.push_back(salt[exp_slot(dly, link, k)]);
    end
    axi(1'b1, fast_stream_pkg::A_COUNT, 32'(cnt), rd, r);
    axi(1'b1, fast_stream_pkg::A_CTRL, 32'({frz, link, dly, 1'b1}), rd, r);
    chk("ctrl_resp", 32'(fast_stream_pkg::RESP_OKAY), 32'(r));
    repeat (40) @(posedge clk);
    chk("early_start", 32'h0, 32'(streaming));
    talk_addr <= 1'b0;
    repeat (10) @(posedge clk);
    talk_addr <= 1'b1;
    n = 0;
    while ((n < 20 || streaming === 1'b1) && n < 60000) begin
      @(posedge clk);
      cmd_in <= 1'($random(seed));
      n++;
    end
    if (n >= 60000) timeout();
    chk("bytes", 32'(nrec * 1024), 32'(lis.got.size()));
    chk("acquires", 32'(nrec), 32'(exp_salt.size()));
    for (int k = 0; k < nrec; k++) begin
      chk("slot", 32'(exp_slot(dly, link, k)), 32'(lis.gslot[k * 1024]));
      for (int i = 0; i < 1024; i++) begin
        chk("byte", 32'(i[7:0] ^ exp_salt[k]), 32'(lis.got[k * 1024 + i]));
      end
    end
    axi(1'b0, fast_stream_pkg::A_CTRL, 32'h0, rd, r);
    chk("arm_clear", 32'h0, 32'(rd[0]));
    $display("test done: link %0d delayed %0d frozen %0d", link, dly, frz);
  endtask : run
  initial begin
    logic [31:0] rd;
    logic [1:0] r;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    axi(1'b0, fast_stream_pkg::A_COUNT, 32'h0, rd, r);
    chk("count_reset", 32'h1, 32'(rd[15:0]));
    axi(1'b1, fast_stream_pkg::A_COUNT, 32'h0, rd, r);
    chk("count_zero", 32'(fast_stream_pkg::RESP_SLVERR), 32'(r));
    axi(1'b1, fast_stream_pkg::A_COUNT, 32'hffff, rd, r);
    axi(1'b0, fast_stream_pkg::A_COUNT, 32'h0, rd, r);
    chk("count_max", 32'hffff, 32'(rd[15:0]));
    axi(1'b0, 5'h14, 32'h0, rd, r);
    chk("unmapped", 32'(fast_stream_pkg::RESP_SLVERR), 32'(r));
    for (int s = 0; s < 4; s++) begin
      salt[s] = 8'($random(seed));
      fill(2'(s), salt[s]);
    end
    talk_addr <= 1'b1;
    repeat (20) @(posedge clk);
    chk("no_request", 32'h0, 32'(streaming));
    $display("test done: registers and idle talk");
    run(1'b0, fast_stream_pkg::LINK_ONE, 1'b0, 16'h2);
    run(1'b1, fast_stream_pkg::LINK_TWO, 1'b0, 16'h1);
    run(1'b0, fast_stream_pkg::LINK_BOTH, 1'b0, 16'h2);
    run(1'b1, fast_stream_pkg::LINK_BOTH, 1'b1, 16'h2);
    finish_test();
  end
endmodule : fast_stream_tb
